// ### rsm_defs.vh
// Constants for the reset and supply monitor block
`ifndef RSM_DEFS_VH
`define RSM_DEFS_VH

// ****************************************
// Register map
// ****************************************
`define RSM_SFR_PAGE0        4'h0
`define RSM_ADDR_SMC         8'hFF
`define RSM_ADDR_RCR         8'hEF

// ****************************************
// Field positions
// ****************************************
`define RSM_SMC_EN_BIT       7
`define RSM_SMC_STAT_BIT     6
`define RSM_SMC_WARN_BIT     5
`define RSM_RCR_POR_BIT      1

// ****************************************
// Reset values
// ****************************************
`define RSM_SMC_EN_RST       1'b1
`define RSM_RCR_SEL_RST      1'b1
`define RSM_PORT_LATCH_RST   8'hFF
`define RSM_RESET_VECTOR     16'h0000
`define RSM_WDT_DIV          4'hC
`define RSM_ZERO8            8'h00

// ****************************************
// Timing
// ****************************************
`define RSM_CLK_MHZ          250
`define RSM_POR_DLY_LO_US    3000
`define RSM_POR_DLY_MID_US   7000
`define RSM_POR_DLY_HI_US    15000
`define RSM_OTHER_RST_CYC    4

`endif

// ### rsm_reset_and_supply_monitor.v
// Reset sequencer and core supply monitor of the microcontroller
`timescale 1ns/1ps
`default_nettype none
`include "rsm_defs.vh"

module rsm_reset_and_supply_monitor #(
    parameter integer CNT_W           = 24,
    parameter integer POR_DLY_LO_CYC  = `RSM_POR_DLY_LO_US * `RSM_CLK_MHZ,
    parameter integer POR_DLY_MID_CYC = `RSM_POR_DLY_MID_US * `RSM_CLK_MHZ,
    parameter integer POR_DLY_HI_CYC  = `RSM_POR_DLY_HI_US * `RSM_CLK_MHZ,
    parameter integer OTHER_RST_CYC   = `RSM_OTHER_RST_CYC
) (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire        clk_en,
    input  wire        vbat_above_por,
    input  wire        vdd_above_rst,
    input  wire        vdd_above_warn,
    input  wire [1:0]  supply_level_sel,
    input  wire        sleep_active,
    input  wire        other_rst_req,
    input  wire        flash_prog_req,
    input  wire [3:0]  sfr_page,
    input  wire [7:0]  sfr_addr,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    input  wire [7:0]  sfr_wdata,
    output reg  [7:0]  sfr_rdata,
    output reg         sys_rst_n,
    output reg         rst_pin_out,
    output reg         rst_pin_oe_n,
    output reg         port_latch_load,
    output reg  [7:0]  port_latch_val,
    output reg         port_open_drain,
    output reg         weak_pullup_en,
    output reg         reset_exit,
    output reg  [15:0] pc_load_addr,
    output reg         clk_sel_internal,
    output reg         wdt_enable,
    output reg  [3:0]  wdt_clk_div,
    output reg         monitor_power_on,
    output reg         supply_warn_ok,
    output reg         ram_invalid
);

// ****************************************
// States and helpers
// ****************************************
localparam [4:0] ST_POR_HOLD = 5'h01;
localparam [4:0] ST_POR_DLY  = 5'h02;
localparam [4:0] ST_RUN      = 5'h04;
localparam [4:0] ST_PF_HOLD  = 5'h08;
localparam [4:0] ST_OTHER    = 5'h10;

localparam integer SYNC_W = 5;

function sfr_hit;
    input [3:0] page;
    input [7:0] addr;
    input [7:0] target;
    begin
        sfr_hit = (page == `RSM_SFR_PAGE0) && (addr == target);
    end
endfunction

// ****************************************
// Input synchronisers
// ****************************************
// Comparator outputs and strap are asynchronous to ref_clk
reg  [SYNC_W-1:0] sync1_reg;
reg  [SYNC_W-1:0] sync2_reg;
wire [SYNC_W-1:0] async_in;
wire              vbat_ok_s;
wire              vdd_rst_ok_s;
wire              vdd_warn_ok_s;
wire [1:0]        level_sel_s;

assign async_in      = {supply_level_sel, vdd_above_warn,
                        vdd_above_rst, vbat_above_por};
assign vbat_ok_s     = sync2_reg[0];
assign vdd_rst_ok_s  = sync2_reg[1];
assign vdd_warn_ok_s = sync2_reg[2];
assign level_sel_s   = sync2_reg[4:3];

always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        sync1_reg <= {SYNC_W{1'b0}};
        sync2_reg <= {SYNC_W{1'b0}};
    end else if (clk_en) begin
        sync1_reg <= async_in;
        sync2_reg <= sync1_reg;
    end
end

// ****************************************
// State registers
// ****************************************
reg [4:0]       st_reg;
reg [4:0]       st_next;
reg [CNT_W-1:0] cnt_reg;
reg [CNT_W-1:0] cnt_next;
reg             mon_en_reg;
reg             mon_en_next;
reg             mon_sel_reg;
reg             mon_sel_next;
reg             por_flag_reg;
reg             por_flag_next;
reg             ram_inv_next;

wire [CNT_W-1:0] dly_lo;
wire [CNT_W-1:0] dly_mid;
wire [CNT_W-1:0] dly_hi;
wire [CNT_W-1:0] dly_other;
wire [CNT_W-1:0] cnt_one;
reg  [CNT_W-1:0] por_dly_load;

assign dly_lo    = POR_DLY_LO_CYC[CNT_W-1:0];
assign dly_mid   = POR_DLY_MID_CYC[CNT_W-1:0];
assign dly_hi    = POR_DLY_HI_CYC[CNT_W-1:0];
assign dly_other = OTHER_RST_CYC[CNT_W-1:0];
assign cnt_one   = {{(CNT_W-1){1'b0}}, 1'b1};

// Delay grows with supply level; strap read as release begins
always @* begin
    case (level_sel_s)
        2'b00:   por_dly_load = dly_lo;
        2'b01:   por_dly_load = dly_mid;
        default: por_dly_load = dly_hi;
    endcase
end

// ****************************************
// Reset causes
// ****************************************
wire sfr_wr_run;
wire wr_smc;
wire wr_rcr;
wire mon_active;
wire pf_trip;
wire flash_err;

assign sfr_wr_run = sfr_wr && st_reg[2];
assign wr_smc     = sfr_wr_run && sfr_hit(sfr_page, sfr_addr, `RSM_ADDR_SMC);
assign wr_rcr     = sfr_wr_run && sfr_hit(sfr_page, sfr_addr, `RSM_ADDR_RCR);
// Sleep masks the trip, but the stored values survive for wake-up
assign mon_active = mon_en_reg && !sleep_active;
assign pf_trip    = mon_active && mon_sel_reg && !vdd_rst_ok_s;
assign flash_err  = flash_prog_req && !mon_active;

// ****************************************
// Sequencer
// ****************************************
always @* begin
    st_next       = st_reg;
    cnt_next      = cnt_reg;
    mon_en_next   = mon_en_reg;
    mon_sel_next  = mon_sel_reg;
    por_flag_next = por_flag_reg;
    ram_inv_next  = ram_invalid;
    case (st_reg)
        ST_POR_HOLD: begin
            if (vbat_ok_s) begin
                st_next  = ST_POR_DLY;
                cnt_next = por_dly_load;
            end
        end
        ST_POR_DLY: begin
            if (cnt_reg <= cnt_one) begin
                st_next       = ST_RUN;
                por_flag_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - cnt_one;
            end
        end
        ST_RUN: begin
            if (pf_trip) begin
                st_next = ST_PF_HOLD;
            end else if (other_rst_req || flash_err) begin
                st_next  = ST_OTHER;
                cnt_next = dly_other;
            end else begin
                if (wr_smc) begin
                    mon_en_next = sfr_wdata[`RSM_SMC_EN_BIT];
                end
                if (wr_rcr) begin
                    mon_sel_next = sfr_wdata[`RSM_RCR_POR_BIT];
                end
            end
        end
        ST_PF_HOLD: begin
            mon_en_next  = 1'b1;
            mon_sel_next = 1'b1;
            if (vdd_rst_ok_s) begin
                st_next       = ST_RUN;
                por_flag_next = 1'b1;
                ram_inv_next  = 1'b1;
            end
        end
        ST_OTHER: begin
            // Monitor enable and select are left alone here
            por_flag_next = 1'b0;
            if (cnt_reg <= cnt_one) begin
                st_next = ST_RUN;
            end else begin
                cnt_next = cnt_reg - cnt_one;
            end
        end
        default: begin
            st_next = ST_POR_HOLD;
        end
    endcase
    // Battery loss overrides every other state
    if (!vbat_ok_s) begin
        st_next      = ST_POR_HOLD;
        mon_en_next  = 1'b1;
        mon_sel_next = 1'b1;
        ram_inv_next = 1'b1;
    end
end

wire in_rst_next;
wire pin_drive_next;

assign in_rst_next    = !st_next[2];
assign pin_drive_next = st_next[0] || st_next[1] || st_next[3];

// Root reset is asynchronous; release is on a clock edge
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        st_reg       <= ST_POR_HOLD;
        cnt_reg      <= {CNT_W{1'b0}};
        mon_en_reg   <= `RSM_SMC_EN_RST;
        mon_sel_reg  <= `RSM_RCR_SEL_RST;
        por_flag_reg <= 1'b0;
        ram_invalid  <= 1'b1;
    end else if (clk_en) begin
        st_reg       <= st_next;
        cnt_reg      <= cnt_next;
        mon_en_reg   <= mon_en_next;
        mon_sel_reg  <= mon_sel_next;
        por_flag_reg <= por_flag_next;
        ram_invalid  <= ram_inv_next;
    end
end

// ****************************************
// Reset outputs
// ****************************************
// Data memory has no clear path; only the core sees sys_rst_n
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        sys_rst_n        <= 1'b0;
        rst_pin_out      <= 1'b0;
        rst_pin_oe_n     <= 1'b0;
        port_latch_load  <= 1'b1;
        port_latch_val   <= `RSM_PORT_LATCH_RST;
        port_open_drain  <= 1'b1;
        weak_pullup_en   <= 1'b1;
        reset_exit       <= 1'b0;
        pc_load_addr     <= `RSM_RESET_VECTOR;
        clk_sel_internal <= 1'b0;
        wdt_enable       <= 1'b0;
        wdt_clk_div      <= `RSM_WDT_DIV;
    end else if (clk_en) begin
        sys_rst_n        <= !in_rst_next;
        rst_pin_out      <= 1'b0;
        rst_pin_oe_n     <= !pin_drive_next;
        port_latch_load  <= in_rst_next;
        port_latch_val   <= `RSM_PORT_LATCH_RST;
        port_open_drain  <= in_rst_next;
        weak_pullup_en   <= 1'b1;
        reset_exit       <= !st_reg[2] && st_next[2];
        pc_load_addr     <= `RSM_RESET_VECTOR;
        clk_sel_internal <= !st_reg[2] && st_next[2];
        wdt_enable       <= !st_reg[2] && st_next[2];
        wdt_clk_div      <= `RSM_WDT_DIV;
    end
end

// ****************************************
// Status outputs
// ****************************************
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        monitor_power_on <= 1'b1;
        supply_warn_ok   <= 1'b0;
    end else if (clk_en) begin
        monitor_power_on <= mon_en_next && !sleep_active;
        supply_warn_ok   <= vdd_warn_ok_s;
    end
end

// ****************************************
// Register read port
// ****************************************
// Bits 4:2 ignore writes and read zero
reg [7:0] rd_next;

always @* begin
    rd_next = `RSM_ZERO8;
    if (sfr_hit(sfr_page, sfr_addr, `RSM_ADDR_SMC)) begin
        rd_next[`RSM_SMC_EN_BIT]   = mon_en_reg;
        rd_next[`RSM_SMC_STAT_BIT] = vdd_rst_ok_s;
        rd_next[`RSM_SMC_WARN_BIT] = vdd_warn_ok_s;
    end else if (sfr_hit(sfr_page, sfr_addr, `RSM_ADDR_RCR)) begin
        rd_next[`RSM_RCR_POR_BIT]  = por_flag_reg;
    end
end

always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        sfr_rdata <= `RSM_ZERO8;
    end else if (clk_en) begin
        if (sfr_rd) begin
            sfr_rdata <= rd_next;
        end
    end
end

endmodule

`default_nettype wire

// ### rsm_checker_sva.sv
// Assertion checker for the reset and supply monitor
`timescale 1ns/1ps
`default_nettype none
module rsm_checker_sva (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        clk_en,
    input wire logic        vdd_above_rst,
    input wire logic        vdd_above_warn,
    input wire logic        sleep_active,
    input wire logic        other_rst_req,
    input wire logic        flash_prog_req,
    input wire logic        sys_rst_n,
    input wire logic        rst_pin_out,
    input wire logic        rst_pin_oe_n,
    input wire logic        port_latch_load,
    input wire logic [7:0]  port_latch_val,
    input wire logic        port_open_drain,
    input wire logic        reset_exit,
    input wire logic [15:0] pc_load_addr,
    input wire logic        clk_sel_internal,
    input wire logic        wdt_enable,
    input wire logic [3:0]  wdt_clk_div,
    input wire logic        monitor_power_on,
    input wire logic        supply_warn_ok
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ****************************************
    // Reset state and exit, reset causes, sleep and warning status
    // ****************************************
    pin_drive_a: assert property (
        !rst_pin_oe_n |-> !sys_rst_n && !rst_pin_out)
        else $error("reset pin driven outside reset");
    latch_hold_a: assert property (
        !sys_rst_n |-> port_latch_load && port_open_drain &&
        port_latch_val == 8'hFF)
        else $error("port latches not forced in reset");
    exit_pulse_a: assert property (
        $rose(sys_rst_n) |-> reset_exit && clk_sel_internal &&
        wdt_enable && pc_load_addr == 16'h0000 && wdt_clk_div == 4'hC)
        else $error("wrong state on reset exit");
    exit_once_a: assert property (
        reset_exit && clk_en |=> !reset_exit)
        else $error("exit pulse longer than one cycle");
    // Four cycles is the hand-over length of a non-supply reset
    other_len_a: assert property (
        vdd_above_rst[*3] ##0 (sys_rst_n && other_rst_req && clk_en)
        |=> !sys_rst_n[*4] ##1 sys_rst_n)
        else $error("other reset length wrong");
    sleep_off_a: assert property (
        sleep_active && clk_en |=> !monitor_power_on)
        else $error("monitor left on in sleep");
    warn_lo_a: assert property (
        (!vdd_above_warn && clk_en)[*4] |=> !supply_warn_ok)
        else $error("warning flag stays set");
    warn_hi_a: assert property (
        (vdd_above_warn && clk_en)[*4] |=> supply_warn_ok)
        else $error("warning flag stays clear");
    flash_err_a: assert property (
        sys_rst_n && flash_prog_req && clk_en ##1
        (!monitor_power_on && clk_en) |-> !sys_rst_n)
        else $error("flash write without monitor not reset");
    cover property ($rose(sys_rst_n));
    cover property (sys_rst_n && other_rst_req);
    cover property (!rst_pin_oe_n && $past(sys_rst_n));
endmodule
`default_nettype wire

// ### rsm_supply_model.sv
// Supply comparator model facing the reset and supply monitor
`timescale 1ns/1ps
`default_nettype none
module rsm_supply_model #(
    parameter int POR_MV  = 900,
    parameter int RST_MV  = 1700,
    parameter int WARN_MV = 1800
) (
    output wire logic vbat_above_por,
    output wire logic vdd_above_rst,
    output wire logic vdd_above_warn
);
    // Thresholds are plain defaults; no hysteresis, so no chatter modelled
    int vbat_mv = 3300;
    int vdd_mv  = 1900;
    assign vbat_above_por = vbat_mv > POR_MV;
    assign vdd_above_rst  = vdd_mv > RST_MV;
    assign vdd_above_warn = vdd_mv > WARN_MV;
endmodule
`default_nettype wire

// ### reset_and_supply_monitor_test.sv
// Self-checking bench for the reset and supply monitor
`timescale 1ns/1ps
`default_nettype none
bind rsm_reset_and_supply_monitor rsm_checker_sva rsm_checker_sva_i (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .vdd_above_rst(vdd_above_rst), .vdd_above_warn(vdd_above_warn),
    .sleep_active(sleep_active), .other_rst_req(other_rst_req),
    .flash_prog_req(flash_prog_req), .sys_rst_n(sys_rst_n),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
    .port_latch_load(port_latch_load), .port_latch_val(port_latch_val),
    .port_open_drain(port_open_drain), .reset_exit(reset_exit),
    .pc_load_addr(pc_load_addr), .clk_sel_internal(clk_sel_internal),
    .wdt_enable(wdt_enable), .wdt_clk_div(wdt_clk_div),
    .monitor_power_on(monitor_power_on), .supply_warn_ok(supply_warn_ok));
module reset_and_supply_monitor_test;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        clk_en = 1'b1;
    logic        sleep_active = 1'b0;
    logic        other_rst_req = 1'b0;
    logic        flash_prog_req = 1'b0;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [1:0]  supply_level_sel = 2'h0;
    logic [3:0]  sfr_page = 4'h0;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    wire logic   vbat_ok, vdd_ok, warn_ok, sys_rst_n, rst_pin_oe_n;
    wire logic   weak_pullup_en, monitor_power_on, ram_invalid;
    wire logic [7:0] sfr_rdata;
    int          n_fail = 0;
    int          checks = 0;
    rsm_supply_model model_i (.vbat_above_por(vbat_ok),
        .vdd_above_rst(vdd_ok), .vdd_above_warn(warn_ok));
    rsm_reset_and_supply_monitor #(.POR_DLY_LO_CYC(10),
        .POR_DLY_MID_CYC(20), .POR_DLY_HI_CYC(30))
    rsm_reset_and_supply_monitor_i (.ref_clk(ref_clk), .nrst(nrst),
        .clk_en(clk_en), .vbat_above_por(vbat_ok), .vdd_above_rst(vdd_ok),
        .vdd_above_warn(warn_ok), .supply_level_sel(supply_level_sel),
        .sleep_active(sleep_active), .other_rst_req(other_rst_req),
        .flash_prog_req(flash_prog_req), .sfr_page(sfr_page),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sys_rst_n(sys_rst_n),
        .rst_pin_out(), .rst_pin_oe_n(rst_pin_oe_n), .port_latch_load(),
        .port_latch_val(), .port_open_drain(), .reset_exit(),
        .weak_pullup_en(weak_pullup_en), .pc_load_addr(),
        .clk_sel_internal(), .wdt_enable(), .wdt_clk_div(),
        .monitor_power_on(monitor_power_on), .supply_warn_ok(),
        .ram_invalid(ram_invalid));
    initial forever #2 ref_clk = ~ref_clk;
    // ****************************************
    // Access tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
        // Idle edge keeps back-to-back strobes apart
        tick(1);
    endtask
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [7:0] exp);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick(1);
        sfr_rd = 1'b0;
        check(nm, sfr_rdata, exp);
        tick(1);
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Bounded wait for the run state; a hang ends the run
    task automatic wait_run(output int n);
        n = 0;
        while (sys_rst_n !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        if (n >= 200) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        int n;
        tick(2);
        nrst = 1'b1;
        tick(3);
        check("pin_drive", {7'h0, rst_pin_oe_n}, 8'h00);
        wait_run(n);
        check("por_delay", {7'h0, n >= 6 && n <= 12}, 8'h01);
        check("pullup", {7'h0, weak_pullup_en}, 8'h01);
        rd("smc_por", 8'hFF, 8'hE0);
        rd("rcr_por", 8'hEF, 8'h02);
        rd("unmapped", 8'hC9, 8'h00);
        sfr_page = 4'h1;
        rd("page_miss", 8'hFF, 8'h00);
        sfr_page = 4'h0;
        wr(8'hFF, 8'h00);
        wr(8'hEF, 8'h00);
        rd("smc_off", 8'hFF, 8'h60);
        model_i.vdd_mv = 1600;
        tick(6);
        check("no_trip", {7'h0, sys_rst_n}, 8'h01);
        rd("smc_low", 8'hFF, 8'h00);
        model_i.vdd_mv = 1900;
        tick(4);
        // Frozen enable must hold off the pending cause
        clk_en = 1'b0;
        other_rst_req = 1'b1;
        tick(3);
        check("freeze", {7'h0, sys_rst_n}, 8'h01);
        clk_en = 1'b1;
        tick(1);
        other_rst_req = 1'b0;
        check("other_rst", {7'h0, sys_rst_n}, 8'h00);
        wait_run(n);
        rd("rcr_other", 8'hEF, 8'h00);
        rd("smc_other", 8'hFF, 8'h60);
        flash_prog_req = 1'b1;
        tick(1);
        flash_prog_req = 1'b0;
        check("flash_rst", {7'h0, sys_rst_n}, 8'h00);
        wait_run(n);
        wr(8'hFF, 8'h80);
        wr(8'hEF, 8'h02);
        sleep_active = 1'b1;
        model_i.vdd_mv = 1600;
        tick(6);
        check("sleep_hold", {7'h0, sys_rst_n}, 8'h01);
        sleep_active = 1'b0;
        tick(2);
        check("pf_pin", {7'h0, rst_pin_oe_n}, 8'h00);
        model_i.vdd_mv = 1900;
        wait_run(n);
        check("pf_fast", {7'h0, n < 8}, 8'h01);
        check("ram_bad", {7'h0, ram_invalid}, 8'h01);
        rd("rcr_pf", 8'hEF, 8'h02);
        rd("smc_pf", 8'hFF, 8'hE0);
        model_i.vdd_mv = 1750;
        tick(5);
        rd("smc_warn", 8'hFF, 8'hC0);
        supply_level_sel = 2'h1;
        nrst = 1'b0;
        tick(2);
        check("rst_rdata", sfr_rdata, 8'h00);
        nrst = 1'b1;
        wait_run(n);
        check("por_mid", {7'h0, n >= 20 && n <= 25}, 8'h01);
        rd("rcr_por2", 8'hEF, 8'h02);
        tally_and_finish();
    end
endmodule
`default_nettype wire
